// file: rtl/trap_and_reset_vectoring.sv
// Purpose: Trap detection, trap ranking, reset entry and interrupt vectoring
// Assumes: Core signals an instruction boundary, trap acknowledge and trap return
// Notes: Device resets requested here leave the status flags intact
// Contract
// - Each source uses vector number equal to interrupt number plus eight.
// - Low-voltage detect is number 42; listed reserved numbers have no source.
// - Numbers 24 and 25 exist only on variants with second serial port.
// - Any reset initialises state and starts fetching at address zero.
// - Address zero holds a jump; the core executes it to the start.
// - Six error conditions also reset the device, lockout among them.
// - Illegal opcode resets only when executed, never when flushed.
// - Traps are non-maskable, levels 8 to 15, top priority bit set.
// - Priority level 7 outside a trap blocks interrupts but not traps.
// - Detected trap waits until the offending instruction completes.
// - Divide by zero aborts and takes the math error trap.
// - Enabled accumulator overflows at bit 31 or 39 raise math trap.
// - Oversized shift amount raises the math error trap.
// - Misaligned, unimplemented or vector-space fetch accesses raise address error.
// - Literal jumps or execution at unimplemented addresses raise address error.
// - Calling through a vector with invalid address raises address error.
// - Stack pointer above limit or below 0x0800 raises stack error.
// - Oscillator failure with fallback to internal RC raises trap.
// - Levels 8 to 11 are soft; math error sits at 11.
// - Levels 12 to 15 hard: address 12, stack 13, oscillator 14.
// - Hard trap halts code until acknowledged; lower hard trap conflicts.
// - Hard trap conflict resets the device and sets flag bit 15.
// - Natural order breaks ties only between equal user levels.
// - Request interrupts only when its level exceeds current priority level.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module trap_and_reset_vectoring import trap_vec_pkg::*; #(
  parameter logic HAS_SECOND_SERIAL = 1'b0,
  parameter logic [15:0] DATA_TOP = 16'h0BFF,
  parameter logic [15:0] X_TOP = 16'h09FF,
  parameter logic [23:0] PROG_TOP = 24'h001FFF,
  parameter logic [23:0] VEC_END = 24'h000100
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Register bus
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Core status
  input wire logic INSTR_DONE,
  input wire logic [3:0] PROCESSOR_PRIORITY_LEVEL,
  input wire logic TRAP_ACK,
  input wire logic TRAP_RETURN,
  // Peripheral requests
  input wire logic [NUM_IRQ-1:0] IRQ_REQ,
  input wire logic [NUM_IRQ-1:0][2:0] IRQ_LEVEL,
  // Trap conditions
  input wire math_ev_t MATH_EV,
  input wire mem_ev_t MEM_EV,
  input wire logic SP_LOAD,
  input wire logic [15:0] SP_VALUE,
  input wire logic OSC_FAIL,
  // Reset conditions
  input wire logic WDT_TIMEOUT,
  input wire logic UNINIT_W_PTR,
  input wire logic ILLEGAL_OPC,
  input wire logic ILLEGAL_FLUSHED,
  input wire logic BROWN_OUT,
  // Core control
  output logic CORE_RESET,
  output logic CORE_HALT,
  output logic PC_FORCE,
  output logic [23:0] PC_VALUE,
  output logic TRAP_TAKE,
  output logic IRQ_TAKE,
  output logic [3:0] NEW_IPL
);
  logic [1:0] ctrl_q;
  logic [15:0] lim_q;
  logic [15:0] flags_q;
  logic [15:0] flags_set;
  logic [15:0] flags_clr;
  logic [5:0] last_vec_q;
  logic [7:0] pend_q;
  logic [7:0] new_t;
  logic [7:0] occ;
  logic [2:0] svc_q;
  logic svc_v_q;
  logic [2:0] taken_q;
  logic wait_ack_q;
  logic [2:0] top_idx;
  logic top_v;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_q;
  logic osc_rise;
  logic math_trap;
  logic addr_trap;
  logic stack_trap;
  logic lockout;
  logic conflict;
  logic ill_exec;
  logic rst_req;
  logic take_trap;
  logic take_irq;
  logic arb_hit;
  logic [5:0] arb_num;
  logic [2:0] arb_lvl;
  rst_state_t rst_st_q;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  // Program address outside implemented memory
  function automatic logic prog_bad(input logic [23:0] a);
    return a > PROG_TOP;
  endfunction

  // Data address outside the space the access may use
  function automatic logic data_bad(input mem_ev_t e);
    if (e.d_mac) begin
      return e.d_mac_y ? (e.d_addr <= X_TOP || e.d_addr > DATA_TOP) : (e.d_addr > X_TOP);
    end
    return e.d_addr > DATA_TOP;
  endfunction

  // Any occupied trap slot above the given index
  function automatic logic busy_above(input logic [7:0] o, input int idx);
    logic r;
    r = 1'b0;
    for (int j = 0; j < 8; j++) begin
      if (j > idx && o[j]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  axil_slave bus (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  irq_arbiter arb (
    .req(IRQ_REQ),
    .lvl(IRQ_LEVEL),
    .has_u2(HAS_SECOND_SERIAL),
    .hit(arb_hit),
    .num(arb_num),
    .win_lvl(arb_lvl)
  );

  // Oscillator fail pin: three-stage synchroniser, agreed level only
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      osc_s1_q <= OSC_FAIL;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      if (osc_s2_q == osc_s3_q) begin
        osc_q <= osc_s2_q;
      end
    end
  end
  assign osc_rise = osc_s2_q && osc_s3_q && !osc_q;

  // Trap condition detection
  assign math_trap = MATH_EV.div_zero
    || (ctrl_q[CTRL_OVF31_EN] && MATH_EV.ovf31 && !MATH_EV.guard_used)
    || (ctrl_q[CTRL_OVF39_EN] && MATH_EV.ovf39 && !MATH_EV.sat_on)
    || MATH_EV.shift_over;
  assign addr_trap = (MEM_EV.d_acc && MEM_EV.d_word && MEM_EV.d_addr[0])
    || (MEM_EV.d_acc && data_bad(MEM_EV))
    || (MEM_EV.p_acc && prog_bad(MEM_EV.p_addr))
    || (MEM_EV.f_exec && MEM_EV.f_addr < VEC_END)
    || (MEM_EV.f_exec && prog_bad(MEM_EV.f_addr))
    || (MEM_EV.br_lit && prog_bad(MEM_EV.br_target))
    || (MEM_EV.vec_call && prog_bad(MEM_EV.vec_target));
  assign stack_trap = SP_LOAD && (SP_VALUE > lim_q || SP_VALUE < STACK_FLOOR);

  always_comb begin
    new_t = 8'h00;
    new_t[LVL_MATH[2:0]] = math_trap;
    new_t[LVL_ADDR[2:0]] = addr_trap;
    new_t[LVL_STACK[2:0]] = stack_trap;
    new_t[LVL_OSC[2:0]] = osc_rise;
  end

  // Slots that are pending, acknowledged or in service
  always_comb begin
    occ = pend_q;
    if (svc_v_q) begin
      occ[svc_q] = 1'b1;
    end
  end

  always_comb begin
    conflict = 1'b0;
    for (int i = HARD_IDX; i < 8; i++) begin
      if (new_t[i] && busy_above(occ, i)) begin
        conflict = 1'b1;
      end
    end
  end

  assign lockout = (new_t & (new_t - 8'h01)) != 8'h00;
  assign ill_exec = ILLEGAL_OPC && !ILLEGAL_FLUSHED;
  assign rst_req = WDT_TIMEOUT || UNINIT_W_PTR || ill_exec || BROWN_OUT || lockout || conflict;

  always_comb begin
    top_v = 1'b0;
    top_idx = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (pend_q[i]) begin
        top_v = 1'b1;
        top_idx = 3'(i);
      end
    end
  end

  // Delivery only at an instruction boundary, traps before interrupts
  assign take_trap = rst_st_q == RS_IDLE && !rst_req && INSTR_DONE && top_v && !wait_ack_q
    && (!svc_v_q || top_idx > svc_q);
  assign take_irq = rst_st_q == RS_IDLE && !rst_req && INSTR_DONE && !top_v && !wait_ack_q
    && PROCESSOR_PRIORITY_LEVEL < IPL_BLOCK
    && arb_hit && {1'b0, arb_lvl} > PROCESSOR_PRIORITY_LEVEL;

  // Reset entry sequence
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rst_st_q <= RS_HOLD;
    end else begin
      unique case (rst_st_q)
        RS_IDLE: begin
          if (rst_req) begin
            rst_st_q <= RS_HOLD;
          end
        end
        RS_HOLD: rst_st_q <= RS_VECTOR;
        RS_VECTOR: rst_st_q <= RS_IDLE;
      endcase
    end
  end

  // Pending traps: detection sets, acknowledge clears, set wins
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N || rst_st_q == RS_HOLD) begin
      pend_q <= 8'h00;
      wait_ack_q <= 1'b0;
      taken_q <= 3'h0;
      svc_v_q <= 1'b0;
      svc_q <= 3'h0;
    end else begin
      pend_q <= (pend_q & ~((TRAP_ACK && wait_ack_q) ? (8'h01 << taken_q) : 8'h00)) | new_t;
      if (take_trap) begin
        wait_ack_q <= 1'b1;
        taken_q <= top_idx;
      end else if (TRAP_ACK && wait_ack_q) begin
        wait_ack_q <= 1'b0;
        svc_v_q <= 1'b1;
        svc_q <= taken_q;
      end else if (TRAP_RETURN) begin
        svc_v_q <= 1'b0;
      end
    end
  end

  // Core control outputs
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      CORE_RESET <= 1'b0;
      PC_FORCE <= 1'b0;
      PC_VALUE <= RESET_PC;
      TRAP_TAKE <= 1'b0;
      IRQ_TAKE <= 1'b0;
      NEW_IPL <= 4'h0;
      CORE_HALT <= 1'b0;
      last_vec_q <= 6'h00;
    end else begin
      CORE_RESET <= rst_st_q == RS_HOLD;
      PC_FORCE <= rst_st_q == RS_VECTOR || take_trap || take_irq;
      TRAP_TAKE <= take_trap;
      IRQ_TAKE <= take_irq;
      CORE_HALT <= pend_q[7:HARD_IDX] != 4'h0;
      if (rst_st_q == RS_VECTOR) begin
        PC_VALUE <= RESET_PC;
      end else if (take_trap) begin
        PC_VALUE <= vec_addr({3'h0, top_idx});
        NEW_IPL <= {1'b1, top_idx};
        last_vec_q <= {3'h0, top_idx};
      end else if (take_irq) begin
        PC_VALUE <= vec_addr(arb_num + VEC_OFS);
        NEW_IPL <= {1'b0, arb_lvl};
        last_vec_q <= arb_num + VEC_OFS;
      end
    end
  end

  // Register writes
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_RST;
      lim_q <= STK_LIM_RST;
    end else if (wr_stb) begin
      if (wr_addr == REG_CTRL && wr_strb[0]) begin
        ctrl_q <= wr_data[1:0];
      end
      if (wr_addr == REG_STK_LIM) begin
        if (wr_strb[0]) begin
          lim_q[7:0] <= wr_data[7:0];
        end
        if (wr_strb[1]) begin
          lim_q[15:8] <= wr_data[15:8];
        end
      end
    end
  end

  // Reset cause flags survive the device reset; write one to clear
  always_comb begin
    flags_set = 16'h0000;
    if (rst_st_q == RS_IDLE) begin
      flags_set[RS_WDT] = WDT_TIMEOUT;
      flags_set[RS_UNINIT] = UNINIT_W_PTR;
      flags_set[RS_ILLEGAL] = ill_exec;
      flags_set[RS_BROWNOUT] = BROWN_OUT;
      flags_set[RS_LOCKOUT] = lockout;
      flags_set[RS_CONFLICT] = conflict;
    end
    flags_clr = (wr_stb && wr_addr == REG_RST_STAT) ? {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & wr_data[15:0] : 16'h0000;
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | flags_set;
    end
  end

  // Register reads and decode
  always_comb begin
    rd_err = 1'b0;
    rd_data = 32'h00000000;
    unique case (rd_addr)
      REG_CTRL: rd_data = {30'h00000000, ctrl_q};
      REG_STK_LIM: rd_data = {16'h0000, lim_q};
      REG_RST_STAT: rd_data = {16'h0000, flags_q};
      REG_TRAP_STAT: rd_data = {20'h00000, svc_v_q, svc_q, pend_q};
      REG_IRQ_STAT: rd_data = {26'h0000000, last_vec_q};
      default: rd_err = 1'b1;
    endcase
  end
  assign wr_err = !(wr_addr == REG_CTRL || wr_addr == REG_STK_LIM || wr_addr == REG_RST_STAT
    || wr_addr == REG_TRAP_STAT || wr_addr == REG_IRQ_STAT);

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence reset_entry_s;
    CORE_RESET ##1 (PC_FORCE && PC_VALUE == RESET_PC);
  endsequence

  reset_entry_a: assert property ((rst_st_q == RS_IDLE && rst_req) |-> ##2 reset_entry_s)
    else $error("Reset request did not produce reset then fetch at zero");
  conflict_flag_a: assert property ((rst_st_q == RS_IDLE && conflict) |=> flags_q[RS_CONFLICT] ##1 CORE_RESET)
    else $error("Hard trap conflict did not flag and reset");
  flushed_ill_a: assert property ((rst_st_q == RS_IDLE && ILLEGAL_OPC && ILLEGAL_FLUSHED && !flags_q[RS_ILLEGAL]
    && !(WDT_TIMEOUT || UNINIT_W_PTR || BROWN_OUT || lockout || conflict)) |=> !CORE_RESET[*2])
    else $error("Flushed illegal opcode caused a reset");
  trap_level_a: assert property (TRAP_TAKE |-> NEW_IPL[3] && PC_VALUE == vec_addr({3'h0, NEW_IPL[2:0]}))
    else $error("Trap taken without a trap level or with wrong vector");
  irq_vector_a: assert property (take_irq |=> IRQ_TAKE && PC_VALUE == vec_addr($past(arb_num) + VEC_OFS))
    else $error("Interrupt vector not number plus eight");
  irq_above_a: assert property (IRQ_TAKE |-> NEW_IPL > $past(PROCESSOR_PRIORITY_LEVEL))
    else $error("Interrupt taken at or below current priority");
  stack_floor_a: assert property ((SP_LOAD && SP_VALUE < STACK_FLOOR && rst_st_q != RS_HOLD)
    |=> pend_q[LVL_STACK[2:0]])
    else $error("Stack underflow did not raise stack trap");
  div_zero_a: assert property ((MATH_EV.div_zero && rst_st_q != RS_HOLD) |=> pend_q[LVL_MATH[2:0]])
    else $error("Divide by zero did not raise math trap");
  boundary_only_a: assert property (TRAP_TAKE |-> $past(INSTR_DONE))
    else $error("Trap delivered away from an instruction boundary");
endmodule

// file: rtl/trap_vec_pkg.sv
// Purpose: Shared constants, types and helpers of the trap and reset vectoring block
// Assumes: Word registers on a 32-bit register bus; trap levels 8..15
// Notes: Trap level L is held at index L-8 of every trap bit vector
package trap_vec_pkg;
  // Interrupt numbering
  localparam int NUM_IRQ = 54;
  localparam logic [5:0] VEC_OFS = 6'h08;
  localparam logic [5:0] IRQ_EXT0 = 6'h00;
  localparam logic [5:0] IRQ_SECOND_SERIAL_RECEIVE_IRQ = 6'h18;
  localparam logic [5:0] IRQ_SECOND_SERIAL_TRANSMIT_IRQ = 6'h19;
  localparam logic [5:0] IRQ_LVD = 6'h2A;
  // Program addresses and stack floor
  localparam logic [23:0] RESET_PC = 24'h000000;
  localparam logic [23:0] IVT_BASE = 24'h000004;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  // Trap levels and blocking level
  localparam logic [3:0] LVL_MATH = 4'hB;
  localparam logic [3:0] LVL_ADDR = 4'hC;
  localparam logic [3:0] LVL_STACK = 4'hD;
  localparam logic [3:0] LVL_OSC = 4'hE;
  localparam logic [3:0] IPL_BLOCK = 4'h7;
  localparam int HARD_IDX = 4;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STK_LIM = 8'h04;
  localparam logic [7:0] REG_RST_STAT = 8'h08;
  localparam logic [7:0] REG_TRAP_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  // Reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] STK_LIM_RST = 16'hFFFF;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  // Field positions
  localparam int CTRL_OVF31_EN = 0;
  localparam int CTRL_OVF39_EN = 1;
  localparam int RS_WDT = 0;
  localparam int RS_UNINIT = 1;
  localparam int RS_ILLEGAL = 2;
  localparam int RS_BROWNOUT = 3;
  localparam int RS_LOCKOUT = 4;
  localparam int RS_CONFLICT = 15;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {RS_IDLE, RS_HOLD, RS_VECTOR} rst_state_t;

  typedef struct packed {
    logic div_zero;
    logic ovf31;
    logic guard_used;
    logic ovf39;
    logic sat_on;
    logic shift_over;
  } math_ev_t;

  typedef struct packed {
    logic d_acc;
    logic d_word;
    logic d_mac;
    logic d_mac_y;
    logic [15:0] d_addr;
    logic p_acc;
    logic [23:0] p_addr;
    logic f_exec;
    logic [23:0] f_addr;
    logic br_lit;
    logic [23:0] br_target;
    logic vec_call;
    logic [23:0] vec_target;
  } mem_ev_t;

  // Slot carries a real source on this variant
  function automatic logic source_present(input logic [5:0] n, input logic has_u2);
    if ((n >= 6'd17 && n <= 6'd22) || (n >= 6'd26 && n <= 6'd41) || n >= 6'd43) begin
      return 1'b0;
    end
    if (n == IRQ_SECOND_SERIAL_RECEIVE_IRQ || n == IRQ_SECOND_SERIAL_TRANSMIT_IRQ) begin
      return has_u2;
    end
    return 1'b1;
  endfunction

  // Vector table entry address for a vector number
  function automatic logic [23:0] vec_addr(input logic [5:0] v);
    return IVT_BASE + {17'h00000, v, 1'b0};
  endfunction
endpackage

// file: rtl/irq_arbiter.sv
// Purpose: Picks the winning peripheral request by user level, then natural order
// Assumes: Requests are already flagged and enabled by the interrupt flag logic
// Notes: Purely combinational
`timescale 1ns/1ns
module irq_arbiter import trap_vec_pkg::*; #(
  parameter int N = NUM_IRQ
) (
  // Requests
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][2:0] lvl,
  input wire logic has_u2,
  // Winner
  output logic hit,
  output logic [5:0] num,
  output logic [2:0] win_lvl
);
  always_comb begin
    hit = 1'b0;
    num = 6'h00;
    win_lvl = 3'h0;
    for (int i = 0; i < N; i++) begin
      // Strictly greater keeps the lower number on equal levels
      if (req[i] && source_present(6'(i), has_u2) && (!hit || lvl[i] > win_lvl)) begin
        hit = 1'b1;
        num = 6'(i);
        win_lvl = lvl[i];
      end
    end
  end
endmodule

// file: rtl/axil_slave.sv
// Purpose: AXI4-Lite slave front end with a simple register strobe port
// Assumes: One write and one read outstanding at most
// Notes: Write answers two cycles after both halves are in, read one cycle after AR
`timescale 1ns/1ns
module axil_slave import trap_vec_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register port
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_got_q;
  logic w_got_q;

  assign wr_stb = aw_got_q && w_got_q && !bvalid;
  assign rd_addr = araddr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      awready <= !aw_got_q && !(awvalid && awready) && !bvalid;
      wready <= !w_got_q && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_stb) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_err ? 32'h00000000 : rd_data;
        rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: verif/core_model.sv
// Purpose: Behavioural core side: instruction pacing, trap acknowledge, return
// Assumes: One level of service at a time
// Notes: Priority is restored after a fixed service time
`timescale 1ns/1ns
module core_model (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic core_reset,
  // Delivery from the block
  input wire logic trap_take,
  input wire logic irq_take,
  input wire logic [3:0] new_ipl,
  input wire logic [3:0] idle_ppl,
  // Core status to the block
  output logic instr_done,
  output logic trap_ack,
  output logic trap_return,
  output logic [3:0] ppl
);
  logic [1:0] pace_q;
  logic [3:0] svc_q;
  logic trap_q;
  // Instruction boundary every fourth cycle
  always_ff @(posedge clk) begin
    pace_q <= (!rst_n || core_reset) ? 2'h0 : pace_q + 2'h1;
    instr_done <= rst_n && !core_reset && pace_q == 2'h3;
  end
  always_ff @(posedge clk) begin
    trap_ack <= rst_n && trap_take;
    trap_return <= rst_n && trap_q && svc_q == 4'h1;
    if (!rst_n || core_reset) begin
      svc_q <= 4'h0;
      trap_q <= 1'b0;
      ppl <= 4'h0;
    end else if (trap_take || irq_take) begin
      svc_q <= 4'h8;
      trap_q <= trap_take;
      ppl <= new_ipl;
    end else if (svc_q != 4'h0) begin
      svc_q <= svc_q - 4'h1;
    end else begin
      ppl <= idle_ppl;
    end
  end
endmodule

// file: verif/trap_and_reset_vectoring_tb_top.sv
// Purpose: Self-checking bench for trap and reset vectoring
// Assumes: core_model paces instructions and acknowledges traps
// Notes: Expected vector loads are queued and matched at every load
`timescale 1ns/1ns
module trap_and_reset_vectoring_tb_top import trap_vec_pkg::*; ;
  logic SYS_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB, ppl, idle, NEW_IPL, rst_src;
  logic [1:0] BRESP, RRESP;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic INSTR_DONE, TRAP_ACK, TRAP_RETURN, SP_LOAD, OSC_FAIL, ILLEGAL_FLUSHED;
  logic CORE_RESET, CORE_HALT, PC_FORCE, TRAP_TAKE, IRQ_TAKE;
  logic [NUM_IRQ-1:0] IRQ_REQ;
  logic [NUM_IRQ-1:0][2:0] IRQ_LEVEL, lvls;
  logic [15:0] SP_VALUE;
  logic [23:0] PC_VALUE;
  math_ev_t MATH_EV;
  mem_ev_t MEM_EV;
  int err_total = 0, samples_checked = 0, cyc = 0, flags = 0, seed = 32'hCF04F454, n, lv, e;
  int q_pc[$], q_ipl[$];
  always #20 SYS_CLK = ~SYS_CLK;
  trap_and_reset_vectoring u_dut (.SYS_CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
    .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .INSTR_DONE, .PROCESSOR_PRIORITY_LEVEL(ppl), .TRAP_ACK, .TRAP_RETURN, .IRQ_REQ, .IRQ_LEVEL, .MATH_EV,
    .MEM_EV, .SP_LOAD, .SP_VALUE, .OSC_FAIL, .WDT_TIMEOUT(rst_src[0]), .UNINIT_W_PTR(rst_src[1]),
    .ILLEGAL_OPC(rst_src[2]), .ILLEGAL_FLUSHED, .BROWN_OUT(rst_src[3]), .CORE_RESET, .CORE_HALT,
    .PC_FORCE, .PC_VALUE, .TRAP_TAKE, .IRQ_TAKE, .NEW_IPL);
  core_model u_core (.clk(SYS_CLK), .rst_n(RST_N), .core_reset(CORE_RESET), .trap_take(TRAP_TAKE),
    .irq_take(IRQ_TAKE), .new_ipl(NEW_IPL), .idle_ppl(idle), .instr_done(INSTR_DONE), .trap_ack(TRAP_ACK),
    .trap_return(TRAP_RETURN), .ppl(ppl));
  task oops(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    samples_checked++;
    if (g !== x) oops($sformatf("%s got %h exp %h", m, g, x));
  endtask
  task expect_vec(input int pc, input int processor_priority_level);
    q_pc.push_back(pc);
    q_ipl.push_back(processor_priority_level);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge SYS_CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge SYS_CLK);
      ad = ad | AWREADY;
      wd = wd | WREADY;
      @(posedge SYS_CLK);
      if (ad) AWVALID <= 1'b0;
      if (wd) WVALID <= 1'b0;
    end
    do @(negedge SYS_CLK); while (BVALID !== 1'b1);
    chk(BRESP, r, "write resp");
    @(posedge SYS_CLK);
    BREADY <= 1'b0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] r);
    @(posedge SYS_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(negedge SYS_CLK); while (ARREADY !== 1'b1);
    @(posedge SYS_CLK);
    ARVALID <= 1'b0;
    do @(negedge SYS_CLK); while (RVALID !== 1'b1);
    chk(RDATA, x, "read data");
    chk(RRESP, r, "read resp");
    @(posedge SYS_CLK);
    RREADY <= 1'b0;
  endtask
  // Ends one-cycle pulses, waits for every queued load, then drops requests
  task finish_test(input string m);
    @(posedge SYS_CLK);
    MATH_EV <= '0;
    MEM_EV <= '0;
    SP_LOAD <= 1'b0;
    rst_src <= 4'h0;
    ILLEGAL_FLUSHED <= 1'b0;
    while (q_pc.size() != 0) @(posedge SYS_CLK);
    @(posedge SYS_CLK);
    IRQ_REQ <= '0;
    repeat (24) @(posedge SYS_CLK);
    $display("test %s finished", m);
  endtask
  task tally_and_finish();
    if (q_pc.size() != 0) oops("vector load missing");
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (PC_FORCE === 1'b1) begin
      if (q_pc.size() == 0) oops("vector load");
      else begin
        chk(PC_VALUE, q_pc.pop_front(), "vector");
        e = q_ipl.pop_front();
        if (e >= 0) chk(NEW_IPL, e, "new level");
        if (e >= 12) chk(CORE_HALT, 1, "halt");
      end
    end
    if (cyc == 5000) begin
      oops("timeout");
      tally_and_finish();
    end
  end
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, SP_LOAD, OSC_FAIL, ILLEGAL_FLUSHED} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, SP_VALUE, rst_src, idle, IRQ_REQ, IRQ_LEVEL} = '0;
    MATH_EV = '0;
    MEM_EV = '0;
    expect_vec(0, -1);
    repeat (4) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    finish_test("reset");
    rchk(REG_STK_LIM, 32'h0000FFFF, RESP_OKAY);
    wr(REG_STK_LIM, 32'h00001234, 4'h1, RESP_OKAY);
    rchk(REG_STK_LIM, 32'h0000FF34, RESP_OKAY);
    wr(8'h40, 32'h1, 4'hF, RESP_SLVERR);
    rchk(8'h40, 32'h0, RESP_SLVERR);
    wr(REG_CTRL, 32'h1, 4'h1, RESP_OKAY);
    finish_test("registers");
    MATH_EV.div_zero <= 1'b1;
    expect_vec(24'h00000A, 11);
    finish_test("divide");
    MATH_EV.ovf31 <= 1'b1;
    expect_vec(24'h00000A, 11);
    finish_test("overflow");
    SP_VALUE <= 16'hFF40;
    SP_LOAD <= 1'b1;
    expect_vec(24'h00000E, 13);
    finish_test("stack");
    MEM_EV.d_acc <= 1'b1;
    MEM_EV.d_word <= 1'b1;
    MEM_EV.d_addr <= 16'h0901;
    expect_vec(24'h00000C, 12);
    finish_test("misaligned");
    for (int i = 0; i < 5; i++) begin
      n = $unsigned($random(seed)) % 19;
      n = (n < 17) ? n : ((n == 17) ? 23 : 42);
      lv = (i == 4) ? 7 : 1 + $unsigned($random(seed)) % 7;
      idle <= (i == 4) ? 4'h7 : 4'(lv - 1);
      lvls = {NUM_IRQ{3'h7}};
      lvls[n] = 3'(lv);
      lvls[42] = 3'(lv);
      repeat (4) @(posedge SYS_CLK);
      IRQ_LEVEL <= lvls;
      IRQ_REQ <= (54'h1 << n) | (54'h1 << 42) | (54'h1 << 24) | (54'h1 << 17);
      if (i == 4) MATH_EV.div_zero <= 1'b1;
      if (i == 4) expect_vec(24'h00000A, 11);
      else expect_vec(4 + 2 * (n + 8), lv);
      finish_test("interrupt");
      rchk(REG_IRQ_STAT, (i == 4) ? 3 : n + 8, RESP_OKAY);
    end
    for (int i = 0; i < 6; i++) begin
      if (i < 4) rst_src <= 4'h1 << i;
      if (i == 4) MATH_EV.div_zero <= 1'b1;
      if (i == 4) SP_LOAD <= 1'b1;
      SP_VALUE <= 16'h0100;
      ILLEGAL_FLUSHED <= 1'b0;
      if (i == 5) rst_src <= 4'h4;
      if (i == 5) ILLEGAL_FLUSHED <= 1'b1;
      if (i < 5) flags |= 1 << i;
      if (i < 5) expect_vec(0, -1);
      finish_test("reset source");
      rchk(REG_RST_STAT, flags, RESP_OKAY);
    end
    tally_and_finish();
  end
endmodule
